// File: rtl/pwm_seq_pkg.sv
// Summary of operation
// - Second primary switches only in 50% mode.
// - First primary drives the main switch.
// - Second rectifier active only in 50% mode.
// - Rectifiers stay off until soft start passes.
// - Wait off-to-rectify gap before rectifier on.
// - Wait rectify-to-on gap before primary on.
// - Fixed variant uses 50 ns gaps.
// - Open gap pins give minimum 8 ns gap.
// - Gaps matter only after soft start ends.
// - Ignore current trip during blanking after rise.
// - Minimum on-time is blanking plus logic delay.
// - Skip pulse on low error, low duty.
// - Rectifiers stay on while skipping after start.
// - Rectifiers stay off when skipping in start.
// - Skip equally on both primaries in 50%.
// - No-rectifier variant runs only 50% mode.
// - Primary and rectifier counts are parameters.
// - Pulse starts at clock, ends on trip.
// - Frame clock runs twice the switching rate.
package pwm_seq_pkg;

  // Clock and time figures; cycle counts round up for least times.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned FIXED_GAP_NS = 50;
  localparam int unsigned MIN_GAP_NS = 8;
  localparam int unsigned FIXED_BLANK_NS = 50;
  localparam logic [7:0] FIXED_GAP_CYC =
    8'((FIXED_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MIN_GAP_CYC = 8'((MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FIXED_BLANK_CYC =
    8'((FIXED_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Duty-limit strap codes.
  localparam logic [1:0] DUTY_SEL_FULL = 2'h0;
  localparam logic [1:0] DUTY_SEL_75 = 2'h1;
  localparam logic [1:0] DUTY_SEL_HALF = 2'h2;

  // Reset values and counter layout.
  localparam logic [1:0] MODE_RESET = DUTY_SEL_FULL;
  localparam int unsigned CNT_W = 12;
  localparam logic [7:0] CNT8_MAX = 8'hff;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // Pulse phase, Gray along off, blank, on.
  typedef enum logic [1:0] {
    PH_OFF = 2'h0,
    PH_BLANK = 2'h1,
    PH_ON = 2'h3
  } pulse_phase_type;

endpackage

// File: rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;

  // Two flops per comparator decision; only the second flop is read.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      meta_ff <= pwm_seq_pkg::SYNC_RESET;
      sync_ff <= pwm_seq_pkg::SYNC_RESET;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// File: rtl/gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic [7:0] delay_i,
  output logic drive_o
);
  logic [7:0] cnt_ff;
  logic drive_ff;

  // The drive rises delay_i + 1 edges after the request rises and drops
  // on the edge after the request falls, so turn-off is never delayed.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 8'h00;
      drive_ff <= 1'b0;
    end else if (!req_i) begin
      cnt_ff <= 8'h00;
      drive_ff <= 1'b0;
    end else if (cnt_ff >= delay_i) begin
      drive_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign drive_o = drive_ff;
endmodule
`default_nettype wire

// File: rtl/pwm_output_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_output_sequencer #(
  parameter int unsigned NUM_PRIMARY = 2,
  parameter int unsigned NUM_RECT = 2,
  parameter bit GAP_PROGRAMMABLE = 1'b1,
  parameter bit BLANK_PROGRAMMABLE = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic frame_clk_i,
  input wire logic [1:0] duty_limit_select_i,
  input wire logic ss_above_i,
  input wire logic err_low_i,
  input wire logic peak_trip_i,
  input wire logic gap_pins_open_i,
  input wire logic [7:0] primary_to_rect_delay_set_i,
  input wire logic [7:0] rect_to_primary_delay_set_i,
  input wire logic [7:0] blank_time_set_i,
  output logic primary_drive_a_o,
  output logic primary_drive_b_o,
  output logic rectifier_drive_a_o,
  output logic rectifier_drive_b_o,
  output logic pulse_skipping_o
);
  pwm_seq_pkg::pulse_phase_type phase_state_ff;
  logic [1:0] mode_ff;
  logic strap_taken_ff;
  logic frame_prev_ff;
  logic half_period_ff;
  logic ch_sel_ff;
  logic skip_ff;
  logic low_duty_ff;
  logic [7:0] blank_cnt_ff;
  logic [7:0] on_run_ff;
  logic [pwm_seq_pkg::CNT_W-1:0] period_cnt_ff;
  logic [pwm_seq_pkg::CNT_W-1:0] on_cnt_ff;
  logic [7:0] prim_low_cnt_ff;
  logic [7:0] rect_low_cnt_ff;
  logic [2:0] sync_w;
  logic ss_done;
  logic err_low;
  logic peak_trip;
  logic half_mode;
  logic frame_rise;
  logic frame_fall;
  logic period_start;
  logic limit_hit;
  logic pulse_on;
  logic prim_now;
  logic nxt_skip;
  logic [7:0] ps_eff;
  logic [7:0] sp_eff;
  logic [7:0] sp_run;
  logic [7:0] blank_eff;
  logic [1:0] prim_req;
  logic [1:0] rect_want;
  logic [1:0] prim_out;
  logic [1:0] rect_out;

  // Comparator decisions arrive through a two-flop synchroniser.
  level_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({peak_trip_i, err_low_i, ss_above_i}),
    .sync_o(sync_w)
  );
  assign ss_done = sync_w[0];
  assign err_low = sync_w[1];
  assign peak_trip = sync_w[2];

  // The strap is caught once after reset release; a strap is static wiring.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mode_ff <= pwm_seq_pkg::MODE_RESET;
      strap_taken_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      mode_ff <= duty_limit_select_i;
      strap_taken_ff <= 1'b1;
    end
  end

  // A variant without rectifiers knows only the half limit.
  assign half_mode = (mode_ff == pwm_seq_pkg::DUTY_SEL_HALF) || (NUM_RECT == 0);

  // Gap and blanking lengths per variant, in cycles.
  always_comb begin
    if (!GAP_PROGRAMMABLE) begin
      ps_eff = pwm_seq_pkg::FIXED_GAP_CYC;
      sp_eff = pwm_seq_pkg::FIXED_GAP_CYC;
    end else if (gap_pins_open_i) begin
      ps_eff = pwm_seq_pkg::MIN_GAP_CYC;
      sp_eff = pwm_seq_pkg::MIN_GAP_CYC;
    end else begin
      ps_eff = primary_to_rect_delay_set_i;
      sp_eff = rect_to_primary_delay_set_i;
    end
    blank_eff = BLANK_PROGRAMMABLE ? blank_time_set_i : pwm_seq_pkg::FIXED_BLANK_CYC;
  end

  // Rectifiers are off in soft start, so no gap is waited there.
  assign sp_run = ss_done ? sp_eff : 8'h00;

  // Two frame clock cycles make one switching period.
  // The previous sample tracks the free-running pin even in reset, so a
  // frame clock that is high at release is not mistaken for a rising edge.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      frame_prev_ff <= frame_clk_i;
      half_period_ff <= 1'b0;
    end else begin
      frame_prev_ff <= frame_clk_i;
      if (frame_rise) begin
        half_period_ff <= ~half_period_ff;
      end
    end
  end

  assign frame_rise = frame_clk_i & ~frame_prev_ff;
  assign frame_fall = ~frame_clk_i & frame_prev_ff;
  assign period_start = frame_rise & half_period_ff;

  // Duty limit: the mid-period edge for half, the second fall for 75%.
  always_comb begin
    if (half_mode) begin
      limit_hit = frame_rise & ~half_period_ff;
    end else if (mode_ff == pwm_seq_pkg::DUTY_SEL_75) begin
      limit_hit = frame_fall & half_period_ff;
    end else begin
      limit_hit = 1'b0;
    end
  end

  // Skip is decided on channel A periods and reused for B, so both
  // primaries always lose the same number of pulses.
  assign nxt_skip = (half_mode && !ch_sel_ff) ? skip_ff : (err_low & low_duty_ff);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ch_sel_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else if (period_start) begin
      ch_sel_ff <= half_mode & ~ch_sel_ff;
      skip_ff <= nxt_skip;
    end
  end

  // Duty of the ending period is judged against a quarter period.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      period_cnt_ff <= '0;
      on_cnt_ff <= '0;
      low_duty_ff <= 1'b0;
    end else if (period_start) begin
      period_cnt_ff <= '0;
      on_cnt_ff <= '0;
      low_duty_ff <= ({on_cnt_ff, 2'b00} < {2'b00, period_cnt_ff});
    end else begin
      if (period_cnt_ff != pwm_seq_pkg::CNT_MAX) begin
        period_cnt_ff <= period_cnt_ff + 12'h001;
      end
      if (prim_now && on_cnt_ff != pwm_seq_pkg::CNT_MAX) begin
        on_cnt_ff <= on_cnt_ff + 12'h001;
      end
    end
  end

  // Pulse phase: on at the period edge, blind to trips while blanking,
  // then off at the peak trip or at the duty limit.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      phase_state_ff <= pwm_seq_pkg::PH_OFF;
    end else begin
      case (phase_state_ff)
        pwm_seq_pkg::PH_OFF: begin
          if (period_start && !nxt_skip) begin
            phase_state_ff <= pwm_seq_pkg::PH_BLANK;
          end
        end
        pwm_seq_pkg::PH_BLANK: begin
          if (period_start && nxt_skip) begin
            phase_state_ff <= pwm_seq_pkg::PH_OFF;
          end else if (limit_hit) begin
            phase_state_ff <= pwm_seq_pkg::PH_OFF;
          end else if (prim_now && blank_cnt_ff >= blank_eff) begin
            phase_state_ff <= pwm_seq_pkg::PH_ON;
          end
        end
        pwm_seq_pkg::PH_ON: begin
          if (period_start && nxt_skip) begin
            phase_state_ff <= pwm_seq_pkg::PH_OFF;
          end else if (limit_hit || peak_trip) begin
            phase_state_ff <= pwm_seq_pkg::PH_OFF;
          end
        end
        default: begin
          phase_state_ff <= pwm_seq_pkg::PH_OFF;
        end
      endcase
    end
  end

  // Blanking counts only while a primary gate is really high.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      blank_cnt_ff <= 8'h00;
    end else if (phase_state_ff != pwm_seq_pkg::PH_BLANK) begin
      blank_cnt_ff <= 8'h00;
    end else if (prim_now && blank_cnt_ff != pwm_seq_pkg::CNT8_MAX) begin
      blank_cnt_ff <= blank_cnt_ff + 8'h01;
    end
  end

  assign pulse_on = (phase_state_ff != pwm_seq_pkg::PH_OFF);
  assign prim_now = |prim_out;

  // Channel A is the main switch; B runs only on alternate half-mode periods.
  assign prim_req[0] = pulse_on & ~(half_mode & ch_sel_ff);
  assign prim_req[1] = pulse_on & half_mode & ch_sel_ff & (NUM_PRIMARY == 2);
  // Rectifiers follow their primary, held off until soft start has passed.
  assign rect_want[0] = ss_done & (NUM_RECT >= 1) & ~prim_req[0];
  assign rect_want[1] = ss_done & (NUM_RECT == 2) & half_mode & ~prim_req[1];

  // Each gate waits for its partner to be off for the matching gap.
  for (genvar i = 0; i < 2; i++) begin : g_chan
    gap_timer u_prim_gap (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .req_i(prim_req[i] & ~rect_out[i]),
      .delay_i(sp_run),
      .drive_o(prim_out[i])
    );
    gap_timer u_rect_gap (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .req_i(rect_want[i] & ~prim_out[i]),
      .delay_i(ps_eff),
      .drive_o(rect_out[i])
    );
  end

  assign primary_drive_a_o = prim_out[0];
  assign primary_drive_b_o = prim_out[1];
  assign rectifier_drive_a_o = rect_out[0];
  assign rectifier_drive_b_o = rect_out[1];
  assign pulse_skipping_o = skip_ff;

  // Helper counters for the checks below: gate high time, partner low time.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      on_run_ff <= 8'h00;
      prim_low_cnt_ff <= 8'h00;
      rect_low_cnt_ff <= 8'h00;
    end else begin
      on_run_ff <= !prim_now ? 8'h00 :
        (on_run_ff == pwm_seq_pkg::CNT8_MAX) ? on_run_ff : on_run_ff + 8'h01;
      prim_low_cnt_ff <= prim_out[0] ? 8'h00 :
        (prim_low_cnt_ff == pwm_seq_pkg::CNT8_MAX) ? prim_low_cnt_ff : prim_low_cnt_ff + 8'h01;
      rect_low_cnt_ff <= rect_out[0] ? 8'h00 :
        (rect_low_cnt_ff == pwm_seq_pkg::CNT8_MAX) ? rect_low_cnt_ff : rect_low_cnt_ff + 8'h01;
    end
  end

  // Second primary never drives outside the half limit.
  AST_B_ONLY_HALF: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !half_mode |-> !primary_drive_b_o)
    else $error("Second primary active outside half mode.");

  AST_RECT_B_ONLY_HALF: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !half_mode |-> !rectifier_drive_b_o)
    else $error("Second rectifier active outside half mode.");

  AST_RECT_OFF_IN_START: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !ss_done |=> !rectifier_drive_a_o && !rectifier_drive_b_o)
    else $error("Rectifier on during soft start.");

  AST_OFF_TO_RECT_GAP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(rectifier_drive_a_o) |-> prim_low_cnt_ff > ps_eff)
    else $error("Rectifier rose before the off-to-rectify gap.");

  AST_RECT_TO_ON_GAP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(primary_drive_a_o) && ss_done |-> rect_low_cnt_ff > sp_eff)
    else $error("Primary rose before the rectify-to-on gap.");

  AST_TRIP_AFTER_BLANK: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    phase_state_ff == pwm_seq_pkg::PH_ON && peak_trip |-> on_run_ff >= blank_eff)
    else $error("Pulse ended by trip inside the blanking time.");

  AST_SKIP_NO_PULSE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    period_start && !half_mode && err_low && low_duty_ff |=> !pulse_on ##1 !prim_now)
    else $error("Primary pulse not skipped.");

  AST_SKIP_RECT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    skip_ff && ss_done && !pulse_on && rectifier_drive_a_o |=> rectifier_drive_a_o)
    else $error("Rectifier dropped during pulse skipping.");

  AST_EQUAL_SKIP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    period_start && half_mode && !ch_sel_ff |=> ch_sel_ff && $stable(skip_ff))
    else $error("Second primary period skipped unlike the first.");

  AST_HALF_LIMIT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    half_mode && limit_hit && !period_start |=> !pulse_on ##2 !prim_now)
    else $error("Pulse ran past half of the period.");
endmodule
`default_nettype wire

// File: tb/gate_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the gate drivers and power stage behind the primary gates.
// The sensed current ramps while either primary conducts and trips after a set count.
module gate_switch_model (
  input wire logic clk_sys_i,
  input wire logic primary_drive_a_i,
  input wire logic primary_drive_b_i,
  input wire logic [7:0] trip_delay_i,
  output logic peak_trip_o
);
  logic [7:0] ramp_ff;

  initial begin
    ramp_ff = 8'h00;
    peak_trip_o = 1'b0;
  end

  // The current collapses once both switches are off, so the trip drops with them.
  // A short trip delay lands inside blanking on purpose; the design must ignore it.
  always @(posedge clk_sys_i) begin
    if (primary_drive_a_i || primary_drive_b_i) begin
      ramp_ff <= (ramp_ff == 8'hff) ? ramp_ff : ramp_ff + 8'h01;
      peak_trip_o <= ((ramp_ff + 8'h01) >= trip_delay_i);
    end else begin
      ramp_ff <= 8'h00;
      peak_trip_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_pwm_output_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_pwm_output_sequencer;
  localparam int FH = 20; // Frame half period in system clocks.
  localparam int PER = 4 * FH; // One switching period spans two frame cycles.
  localparam int LIMIT = 20000;
  typedef struct {
    logic [1:0] mode;
    bit ss;
    bit err;
    int trip;
    bit open_g;
  } row_type;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic frame_clk_i = 1'b0;
  logic [1:0] duty_limit_select_i = 2'h0;
  logic ss_above_i = 1'b0;
  logic err_low_i = 1'b0;
  logic gap_pins_open_i = 1'b0;
  logic [7:0] ps_set = 8'h01;
  logic [7:0] sp_set = 8'h01;
  logic [7:0] blank_set = 8'h02;
  logic [7:0] trip_set = 8'h0a;
  logic peak_trip_i;
  logic prim_a, prim_b, rect_a, rect_b, skipping;
  logic [1:0] prim, rect;
  logic [1:0] prim_q = 2'h0;
  logic [1:0] rect_q = 2'h0;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int exp_q[$];
  int ps_exp, sp_exp, n_rise;
  int ss_low = 0;
  int ss_high = 0;
  int on_len[2] = '{0, 0};
  int plow[2] = '{255, 255};
  int rlow[2] = '{255, 255};
  bit skip_seen, rect_due;
  row_type rows[7] = '{
    '{pwm_seq_pkg::DUTY_SEL_FULL, 1'b1, 1'b0, 0, 1'b0},
    '{pwm_seq_pkg::DUTY_SEL_75, 1'b1, 1'b0, 200, 1'b0},
    '{pwm_seq_pkg::DUTY_SEL_HALF, 1'b1, 1'b0, 200, 1'b0},
    '{pwm_seq_pkg::DUTY_SEL_HALF, 1'b1, 1'b0, 1, 1'b0},
    '{pwm_seq_pkg::DUTY_SEL_HALF, 1'b1, 1'b1, 2, 1'b0},
    '{pwm_seq_pkg::DUTY_SEL_FULL, 1'b0, 1'b1, 2, 1'b0},
    '{2'h3, 1'b1, 1'b0, 0, 1'b1}};

  // The system clock toggles every half period.
  always #10 clk_sys_i = ~clk_sys_i;

  // The frame clock runs free at twice the switching rate.
  always begin
    repeat (FH) @(posedge clk_sys_i);
    #2;
    frame_clk_i = ~frame_clk_i;
  end

  pwm_output_sequencer #(
    .NUM_PRIMARY(2),
    .NUM_RECT(2),
    .GAP_PROGRAMMABLE(1'b1),
    .BLANK_PROGRAMMABLE(1'b1)
  ) dut_u (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .frame_clk_i(frame_clk_i),
    .duty_limit_select_i(duty_limit_select_i),
    .ss_above_i(ss_above_i),
    .err_low_i(err_low_i),
    .peak_trip_i(peak_trip_i),
    .gap_pins_open_i(gap_pins_open_i),
    .primary_to_rect_delay_set_i(ps_set),
    .rect_to_primary_delay_set_i(sp_set),
    .blank_time_set_i(blank_set),
    .primary_drive_a_o(prim_a),
    .primary_drive_b_o(prim_b),
    .rectifier_drive_a_o(rect_a),
    .rectifier_drive_b_o(rect_b),
    .pulse_skipping_o(skipping)
  );

  gate_switch_model partner_u (
    .clk_sys_i(clk_sys_i),
    .primary_drive_a_i(prim_a),
    .primary_drive_b_i(prim_b),
    .trip_delay_i(trip_set),
    .peak_trip_o(peak_trip_i)
  );

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Counts: checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The watcher samples settled outputs 1 ns after each edge and pops a note per pulse.
  // Gap counters keep running through reset so the first pulse after it is judged fairly.
  always @(posedge clk_sys_i) begin
    #1;
    prim = {prim_b, prim_a};
    rect = {rect_b, rect_a};
    ss_low = ss_above_i ? 0 : ss_low + 1;
    ss_high = ss_above_i ? ss_high + 1 : 0;
    // Soft start passes two sync flops, then the rectifier waits its gap plus one edge.
    rect_due = skipping === 1'b1 && ss_high >= ps_exp + 3 && plow[0] >= 8 && plow[1] >= 8;
    if (reset_n_i) begin
      if (skipping === 1'b1) skip_seen = 1'b1;
      if (duty_limit_select_i !== pwm_seq_pkg::DUTY_SEL_HALF) chk(0, {prim[1], rect[1]});
      if (ss_low >= 4) chk(0, rect);
      chk(0, prim & rect);
      if (rect_due) chk(1, |rect);
      for (int c = 0; c < 2; c++) begin
        if (prim[c] === 1'b1 && prim_q[c] === 1'b0) begin
          n_rise++;
          chk(exp_q.size() > 0 ? exp_q.pop_front() : 2, c);
          chk(1, rlow[c] >= sp_exp);
          on_len[c] = 0;
        end
        if (prim[c] === 1'b0 && prim_q[c] === 1'b1) begin
          chk(1, on_len[c] >= blank_set);
          if (duty_limit_select_i === pwm_seq_pkg::DUTY_SEL_HALF) chk(1, on_len[c] <= 2 * FH);
          if (duty_limit_select_i === pwm_seq_pkg::DUTY_SEL_75) chk(1, on_len[c] <= 3 * FH);
        end
        if (rect[c] === 1'b1 && rect_q[c] === 1'b0) chk(1, plow[c] >= ps_exp);
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (prim[c] === 1'b1) on_len[c]++;
      plow[c] = (prim[c] === 1'b1) ? 0 : plow[c] + 1;
      rlow[c] = (rect[c] === 1'b1) ? 0 : rlow[c] + 1;
    end
    prim_q = prim;
    rect_q = rect;
  end

  // A hang is cut short well beyond the planned run of about seven thousand cycles.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      close_out();
    end
  end

  // Each row resets the block, since the strap is only caught at reset release.
  // Soft start stays low for three periods so rectifiers are seen held off first.
  task automatic run_row(input row_type rw);
    @(posedge clk_sys_i);
    #2;
    reset_n_i = 1'b0;
    ss_above_i = 1'b0;
    err_low_i = 1'b0;
    duty_limit_select_i = rw.mode;
    gap_pins_open_i = rw.open_g;
    ps_set = 8'(1 + $urandom % 5);
    sp_set = 8'(1 + $urandom % 5);
    blank_set = 8'(2 + $urandom % 6);
    trip_set = (rw.trip == 0) ? 8'(10 + $urandom % 11) : 8'(rw.trip);
    ps_exp = rw.open_g ? int'(pwm_seq_pkg::MIN_GAP_CYC) : int'(ps_set);
    sp_exp = rw.open_g ? int'(pwm_seq_pkg::MIN_GAP_CYC) : int'(sp_set);
    exp_q.delete();
    // In half mode the first period after reset belongs to the second primary.
    for (int i = 0; i < 40; i++) begin
      exp_q.push_back(rw.mode == pwm_seq_pkg::DUTY_SEL_HALF ? (i + 1) % 2 : 0);
    end
    skip_seen = 1'b0;
    n_rise = 0;
    repeat (8) @(posedge clk_sys_i);
    #2;
    reset_n_i = 1'b1;
    repeat (3 * PER) @(posedge clk_sys_i);
    #2;
    ss_above_i = rw.ss;
    err_low_i = rw.err;
    repeat (9 * PER) @(posedge clk_sys_i);
    chk(1, n_rise > 0);
    chk(rw.err, skip_seen);
  endtask

  // The seed is set once, then every row of the table runs in turn.
  initial begin
    void'($urandom(93175));
    for (int r = 0; r < 7; r++) run_row(rows[r]);
    close_out();
  end
endmodule
`default_nettype wire
